// ==== rtl/iopx_pkg.sv ====
`default_nettype none
package iopx_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_PERIOD_NS   = 10;
	localparam int unsigned ALERT_VALID_NS  = 4000;
	// longest time, rounds down
	localparam int unsigned ALERT_VALID_CYC = ALERT_VALID_NS / CLK_PERIOD_NS;

	// ----------------------------------------
	// bus addressing and commands
	// ----------------------------------------
	localparam logic [6:0] SLAVE_ADDR_BASE = 7'h20;
	localparam int unsigned RW_BIT         = 0;
	localparam logic [1:0] CMD_INPUT       = 2'h0;
	localparam logic [1:0] CMD_OUTPUT      = 2'h1;
	localparam logic [1:0] CMD_POLARITY    = 2'h2;
	localparam logic [1:0] CMD_CONFIG      = 2'h3;
	localparam logic [3:0] ACK_SLOT        = 4'h8;
	localparam logic [3:0] BYTE_END        = 4'h9;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] OUTPUT_RST   = 8'hff;
	localparam logic [7:0] POLARITY_RST = 8'h00;
	localparam logic [7:0] CONFIG_RST   = 8'hff;
	localparam logic [1:0] INIT_DONE    = 2'h3;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [2:0] {
		st_idle,
		st_addr,
		st_cmd,
		st_wr,
		st_rd
	} iopx_state_t;

	typedef struct packed {
		logic bit_v;
		logic tog;
	} iopx_link_t;

	typedef struct packed {
		logic        scl_s1;
		logic        scl_s2;
		logic        scl_p;
		logic        sda_s1;
		logic        sda_s2;
		logic        sda_p;
		logic        tog_s1;
		logic        tog_s2;
		logic        tog_p;
		logic [7:0]  pin_s1;
		logic [7:0]  pin_s2;
		logic [2:0]  sel_s1;
		logic [2:0]  sel_s2;
		logic [1:0]  init_cnt;
		iopx_state_t state;
		logic [3:0]  bitcnt;
		logic [7:0]  shreg;
		logic [7:0]  tx;
		logic        mnack;
		logic [1:0]  cmd;
		logic [7:0]  outp;
		logic [7:0]  pol;
		logic [7:0]  dir;
		logic [7:0]  inreg;
		logic        sda_oe;
		logic        sda_lvl;
		logic        alert_oe;
		logic        alert_lvl;
		logic [7:0]  pins_out;
		logic [7:0]  pins_oe;
		logic [7:0]  hs;
		logic [7:0]  ls;
	} iopx_sys_t;

endpackage
`default_nettype wire

// ==== rtl/iopx_expander.sv ====
`timescale 1ns/1ps
`default_nettype none
module iopx_expander (
	input  wire logic       clock,
	input  wire logic       reset,
	input  wire logic       scl,
	input  wire logic       sda_in,
	output var  logic       sda_out,
	output var  logic       sda_oe,
	input  wire logic       addr_sel_bit0,
	input  wire logic       addr_sel_bit1,
	input  wire logic       addr_sel_bit2,
	input  wire logic [7:0] port_pins_in,
	output var  logic [7:0] port_pins_out,
	output var  logic [7:0] port_pins_oe,
	output var  logic [7:0] high_side_driver,
	output var  logic [7:0] low_side_driver,
	output var  logic       alert_out,
	output var  logic       alert_oe
);

	// ----------------------------------------
	// link domain: bit capture on scl
	// ----------------------------------------
	iopx_pkg::iopx_link_t lnk_q;
	iopx_pkg::iopx_link_t lnk_d;

	always_comb begin
		lnk_d       = lnk_q;
		lnk_d.bit_v = sda_in;
		lnk_d.tog   = ~lnk_q.tog;
	end

	always_ff @(posedge scl or posedge reset) begin
		if (reset) begin
			lnk_q <= '0;
		end else begin
			lnk_q <= lnk_d;
		end
	end

	// ----------------------------------------
	// system domain
	// ----------------------------------------
	iopx_pkg::iopx_sys_t s_q;
	iopx_pkg::iopx_sys_t s_d;

	logic       scl_fall;
	logic       start_ev;
	logic       stop_ev;
	logic       bit_ev;
	logic       addr_hit;
	logic       rd_ack_ev;
	logic [7:0] mism;
	logic [7:0] rdval;
	logic [6:0] my_addr;

	always_comb begin
		s_d = s_q;
		// two-stage synchronisers; stage two and its delayed copy are read, stage one only by an assertion
		s_d.scl_s1 = scl;
		s_d.scl_s2 = s_q.scl_s1;
		s_d.scl_p  = s_q.scl_s2;
		s_d.sda_s1 = sda_in;
		s_d.sda_s2 = s_q.sda_s1;
		s_d.sda_p  = s_q.sda_s2;
		// toggle crossing; bit value stays put until next scl rise
		s_d.tog_s1 = lnk_q.tog;
		s_d.tog_s2 = s_q.tog_s1;
		s_d.tog_p  = s_q.tog_s2;
		s_d.pin_s1 = port_pins_in;
		s_d.pin_s2 = s_q.pin_s1;
		s_d.sel_s1 = {addr_sel_bit2, addr_sel_bit1, addr_sel_bit0};
		s_d.sel_s2 = s_q.sel_s1;

		scl_fall = s_q.scl_p & ~s_q.scl_s2;
		start_ev = s_q.scl_s2 & s_q.scl_p & s_q.sda_p & ~s_q.sda_s2;
		stop_ev  = s_q.scl_s2 & s_q.scl_p & ~s_q.sda_p & s_q.sda_s2;
		bit_ev   = s_q.tog_s2 ^ s_q.tog_p;
		my_addr  = iopx_pkg::SLAVE_ADDR_BASE | {4'h0, s_q.sel_s2};
		addr_hit = (s_q.shreg[7:1] == my_addr);

		mism = (s_q.pin_s2 ^ s_q.inreg) & s_q.dir;

		if (s_q.cmd == iopx_pkg::CMD_INPUT) begin
			rdval = s_q.inreg ^ s_q.pol;
		end else if (s_q.cmd == iopx_pkg::CMD_OUTPUT) begin
			rdval = s_q.outp;
		end else if (s_q.cmd == iopx_pkg::CMD_POLARITY) begin
			rdval = s_q.pol;
		end else begin
			rdval = s_q.dir;
		end

		// ack rise before an input byte
		rd_ack_ev = bit_ev && (s_q.bitcnt == iopx_pkg::ACK_SLOT) && (s_q.cmd == iopx_pkg::CMD_INPUT)
			&& (((s_q.state == iopx_pkg::st_addr) && s_q.shreg[iopx_pkg::RW_BIT])
			|| ((s_q.state == iopx_pkg::st_rd) && !lnk_q.bit_v));

		// capture pin levels once the synchronisers hold real data
		if (s_q.init_cnt != iopx_pkg::INIT_DONE) begin
			s_d.init_cnt = s_q.init_cnt + 2'h1;
			s_d.inreg    = s_q.pin_s2;
		end

		// read latches levels, clearing the alert
		// a change in this very cycle is absorbed
		if (rd_ack_ev) begin
			s_d.inreg = s_q.pin_s2;
		end

		if (start_ev) begin
			s_d.state  = iopx_pkg::st_addr;
			s_d.bitcnt = 4'h0;
			s_d.sda_oe = 1'b0;
		end else if (stop_ev) begin
			s_d.state  = iopx_pkg::st_idle;
			s_d.sda_oe = 1'b0;
		end else if (s_q.state != iopx_pkg::st_idle) begin
			if (bit_ev) begin
				if (s_q.bitcnt < iopx_pkg::ACK_SLOT) begin
					s_d.shreg = {s_q.shreg[6:0], lnk_q.bit_v};
				end else if (s_q.bitcnt == iopx_pkg::ACK_SLOT) begin
					s_d.mnack = lnk_q.bit_v;
				end
				if (s_q.bitcnt < iopx_pkg::BYTE_END) begin
					s_d.bitcnt = s_q.bitcnt + 4'h1;
				end
			end
			if (scl_fall) begin
				if (s_q.bitcnt == iopx_pkg::ACK_SLOT) begin
					case (s_q.state)
						iopx_pkg::st_addr: begin
							// foreign address: drop off the bus quietly
							if (addr_hit) begin
								s_d.sda_oe = 1'b1;
							end else begin
								s_d.state = iopx_pkg::st_idle;
							end
						end
						iopx_pkg::st_cmd: begin
							s_d.cmd    = s_q.shreg[1:0];
							s_d.sda_oe = 1'b1;
						end
						iopx_pkg::st_wr: begin
							if (s_q.cmd == iopx_pkg::CMD_OUTPUT) begin
								s_d.outp = s_q.shreg;
							end else if (s_q.cmd == iopx_pkg::CMD_POLARITY) begin
								s_d.pol = s_q.shreg;
							end else if (s_q.cmd == iopx_pkg::CMD_CONFIG) begin
								// switching to input may alert at once
								s_d.dir = s_q.shreg;
							end
							s_d.sda_oe = 1'b1;
						end
						default: begin
							s_d.sda_oe = 1'b0;
						end
					endcase
				end else if (s_q.bitcnt == iopx_pkg::BYTE_END) begin
					s_d.bitcnt = 4'h0;
					s_d.sda_oe = 1'b0;
					case (s_q.state)
						iopx_pkg::st_addr: begin
							if (s_q.shreg[iopx_pkg::RW_BIT]) begin
								s_d.state  = iopx_pkg::st_rd;
								s_d.tx     = rdval;
								s_d.sda_oe = ~rdval[7];
							end else begin
								s_d.state = iopx_pkg::st_cmd;
							end
						end
						iopx_pkg::st_cmd: begin
							s_d.state = iopx_pkg::st_wr;
						end
						iopx_pkg::st_rd: begin
							if (s_q.mnack) begin
								s_d.state = iopx_pkg::st_idle;
							end else begin
								s_d.tx     = rdval;
								s_d.sda_oe = ~rdval[7];
							end
						end
						default: begin
							s_d.state = s_q.state;
						end
					endcase
				end else if (s_q.state == iopx_pkg::st_rd) begin
					s_d.tx     = {s_q.tx[6:0], 1'b0};
					s_d.sda_oe = ~s_q.tx[6];
				end
			end
		end

		s_d.pins_oe  = ~s_q.dir;
		s_d.pins_out = s_q.outp;
		s_d.hs       = ~s_q.dir & s_q.outp;
		s_d.ls       = ~s_q.dir & ~s_q.outp;
		// re-arms as soon as levels differ again
		// alert_oe one cycle after the mismatch
		// held off while the latch loads after reset: no false pulse
		s_d.alert_oe  = (|mism) & (s_q.init_cnt == iopx_pkg::INIT_DONE);
		s_d.alert_lvl = 1'b0;
		s_d.sda_lvl   = 1'b0;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			s_q       <= '0;
			s_q.outp  <= iopx_pkg::OUTPUT_RST;
			s_q.pol   <= iopx_pkg::POLARITY_RST;
			s_q.dir   <= iopx_pkg::CONFIG_RST;
			s_q.state <= iopx_pkg::st_idle;
		end else begin
			s_q <= s_d;
		end
	end

	assign sda_out          = s_q.sda_lvl;
	assign sda_oe           = s_q.sda_oe;
	assign port_pins_out    = s_q.pins_out;
	assign port_pins_oe     = s_q.pins_oe;
	assign high_side_driver = s_q.hs;
	assign low_side_driver  = s_q.ls;
	assign alert_out        = s_q.alert_lvl;
	assign alert_oe         = s_q.alert_oe;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	localparam int alert_win = iopx_pkg::ALERT_VALID_CYC;

	property p_alert_on_mismatch;
		@(posedge clock) disable iff (reset)
		(mism != 8'h00 && s_q.init_cnt == iopx_pkg::INIT_DONE) |=> alert_oe;
	endproperty
	a_alert_on_mismatch: assert property (p_alert_on_mismatch) else $error("alert missing on mismatch");

	property p_alert_valid_time;
		@(posedge clock) disable iff (reset)
		($changed(s_q.pin_s1 & s_q.dir) && s_q.state == iopx_pkg::st_idle
			&& s_q.init_cnt == iopx_pkg::INIT_DONE
			&& $stable(s_q.inreg) && $stable(s_q.dir)
			&& ((port_pins_in ^ s_q.inreg) & s_q.dir) != 8'h00)
		|-> ##[1:alert_win] alert_oe;
	endproperty
	a_alert_valid_time: assert property (p_alert_valid_time) else $error("alert late");

	property p_outputs_no_alert;
		@(posedge clock) disable iff (reset)
		(s_q.dir == 8'h00)[*2] |=> !alert_oe;
	endproperty
	a_outputs_no_alert: assert property (p_outputs_no_alert) else $error("output pin raised alert");

	property p_read_clears;
		@(posedge clock) disable iff (reset)
		rd_ack_ev |=> (s_q.inreg == $past(s_q.pin_s2))
			##1 ($past(s_q.pin_s2 != s_q.inreg) || !alert_oe);
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("read did not latch input");

	property p_foreign_idle;
		@(posedge clock) disable iff (reset)
		(s_q.state == iopx_pkg::st_idle && s_q.init_cnt == iopx_pkg::INIT_DONE) |=> $stable(s_q.inreg);
	endproperty
	a_foreign_idle: assert property (p_foreign_idle) else $error("idle bus changed input latch");

	property p_drivers_exclusive;
		@(posedge clock) disable iff (reset)
		((high_side_driver & low_side_driver) == 8'h00) && ((high_side_driver | low_side_driver) == port_pins_oe);
	endproperty
	a_drivers_exclusive: assert property (p_drivers_exclusive) else $error("driver pair wrong");

	property p_inputs_released;
		@(posedge clock) disable iff (reset)
		(s_q.dir == 8'hff) |=> (port_pins_oe == 8'h00) && (high_side_driver == 8'h00);
	endproperty
	a_inputs_released: assert property (p_inputs_released) else $error("input pin driven");

	property p_high_follows_out;
		@(posedge clock) disable iff (reset)
		1'b1 |=> high_side_driver == ($past(s_q.outp) & ~$past(s_q.dir));
	endproperty
	a_high_follows_out: assert property (p_high_follows_out) else $error("high side mismatch");

	property p_power_defaults;
		@(posedge clock) disable iff (reset)
		(s_q.init_cnt == 2'h0) |-> (s_q.dir == 8'hff) && (s_q.outp == 8'hff) && (s_q.pol == 8'h00)
			&& (s_q.state == iopx_pkg::st_idle);
	endproperty
	a_power_defaults: assert property (p_power_defaults) else $error("bad reset defaults");

	property p_cmd_sticky;
		@(posedge clock) disable iff (reset)
		(s_q.state != iopx_pkg::st_cmd) |=> $stable(s_q.cmd);
	endproperty
	a_cmd_sticky: assert property (p_cmd_sticky) else $error("command changed outside command byte");

	property p_no_ack_foreign;
		@(posedge clock) disable iff (reset)
		(s_q.state == iopx_pkg::st_addr && s_q.bitcnt == iopx_pkg::ACK_SLOT && scl_fall && !addr_hit
			&& !start_ev && !stop_ev) |=> !sda_oe && s_q.state == iopx_pkg::st_idle;
	endproperty
	a_no_ack_foreign: assert property (p_no_ack_foreign) else $error("acked foreign address");

	property p_open_drain;
		@(posedge clock) disable iff (reset)
		!alert_out && !sda_out;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("open drain drove high");

	property p_pins_start_input;
		@(posedge clock) disable iff (reset)
		(s_q.init_cnt != iopx_pkg::INIT_DONE) |-> (port_pins_oe == 8'h00) && !alert_oe;
	endproperty
	a_pins_start_input: assert property (p_pins_start_input) else $error("pin driven or alert after reset");

	property p_polarity_report;
		@(posedge clock) disable iff (reset)
		(scl_fall && !start_ev && !stop_ev && s_q.state == iopx_pkg::st_addr && s_q.bitcnt == iopx_pkg::BYTE_END
			&& s_q.shreg[iopx_pkg::RW_BIT] && s_q.cmd == iopx_pkg::CMD_INPUT)
		|=> s_q.tx == ($past(s_q.inreg) ^ $past(s_q.pol));
	endproperty
	a_polarity_report: assert property (p_polarity_report) else $error("input byte not polarity adjusted");

	property p_pins_follow_out;
		@(posedge clock) disable iff (reset)
		1'b1 |=> port_pins_out == $past(s_q.outp);
	endproperty
	a_pins_follow_out: assert property (p_pins_follow_out) else $error("pin output level wrong");

endmodule // iopx_expander
`default_nettype wire

// ==== testbench/iopx_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// bus host: drives clock, pulls data low
// ----------------------------------------
module iopx_host_model (
	output var  logic scl,
	output var  logic sda_low,
	input  wire logic sda_line
);
	// quarter of a 125 ns bit; clock stands high between frames
	localparam realtime Q = 31.25;

	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task automatic start();
		sda_low = 1'b0;
		#Q scl = 1'b1;
		#Q sda_low = 1'b1;
		#Q scl = 1'b0;
		#Q;
	endtask

	task automatic stop();
		sda_low = 1'b1;
		#Q scl = 1'b1;
		#Q sda_low = 1'b0;
		#(2 * Q);
	endtask

	// open drain, released line reads pulled high
	task automatic bit_io(input logic b, output logic r);
		sda_low = !b;
		#Q scl = 1'b1;
		#Q r = sda_line;
		#Q scl = 1'b0;
		#Q;
	endtask

	// msb first, ack is a low ninth bit
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask

	task automatic rbyte(input logic mack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(!mack, r);
	endtask
endmodule // iopx_host_model
`default_nettype wire

// ==== testbench/tb_iopx_expander.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_iopx_expander;
	// ----------------------------------------
	// nets and instances
	// ----------------------------------------
	logic       clock, reset, scl, sda_low, sda_in, sda_out, sda_oe;
	logic [2:0] sel;
	logic [7:0] ext, pins, pins_out, pins_oe, hs, ls, v, pol;
	logic       alert_out, alert_oe;
	logic [6:0] adr;
	int         err_total = 0;
	int         n_tests = 0;

	// pull-up on the open-drain data line only
	assign sda_in = !(sda_oe || sda_low);
	assign pins = (pins_oe & pins_out) | (~pins_oe & ext);

	iopx_host_model u_host (.scl(scl), .sda_low(sda_low), .sda_line(sda_in));

	iopx_expander u_dut (
		.clock(clock), .reset(reset), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
		.addr_sel_bit0(sel[0]), .addr_sel_bit1(sel[1]), .addr_sel_bit2(sel[2]),
		.port_pins_in(pins), .port_pins_out(pins_out), .port_pins_oe(pins_oe),
		.high_side_driver(hs), .low_side_driver(ls), .alert_out(alert_out), .alert_oe(alert_oe)
	);

	initial begin
		clock = 1'b0;
		forever #5 clock = !clock;
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic close_out();
		if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// wr: write byte; sc: set command before read
	task automatic xfer(input logic [6:0] a, input logic [1:0] c, input logic wr, input logic sc,
			input logic [7:0] wd, input logic ek, output logic [7:0] rd);
		logic k;
		rd = 8'h00;
		u_host.start();
		if (wr || sc) begin
			u_host.wbyte({a, 1'b0}, k);
			chk("addr_ack", {7'h00, k}, {7'h00, ek});
			if (k) u_host.wbyte({6'h00, c}, k);
			if (k && wr) u_host.wbyte(wd, k);
			if (!wr) u_host.start();
		end
		if (!wr) begin
			u_host.wbyte({a, 1'b1}, k);
			chk("rd_ack", {7'h00, k}, {7'h00, ek});
			if (k) u_host.rbyte(1'b0, rd);
		end
		u_host.stop();
	endtask

	task automatic reg_wr(input logic [1:0] c, input logic [7:0] d);
		logic [7:0] x;
		xfer(adr, c, 1'b1, 1'b0, d, 1'b1, x);
	endtask

	task automatic reg_rd(input string nm, input logic [1:0] c, input logic sc, input logic [7:0] e);
		logic [7:0] x;
		xfer(adr, c, 1'b0, sc, 8'h00, 1'b1, x);
		chk(nm, x, e);
	endtask

	// hold: wait the full limit, else stop once matched
	task automatic al(input logic e, input logic hold);
		if (hold) repeat (iopx_pkg::ALERT_VALID_CYC) @(negedge clock);
		else for (int i = 0; i < iopx_pkg::ALERT_VALID_CYC && alert_oe !== e; i++) @(negedge clock);
		chk("alert_oe", {7'h00, alert_oe}, {7'h00, e});
	endtask

	initial begin
		#300us;
		err_total++;
		close_out();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		reset = 1'b1;
		sel = 3'h0;
		ext = 8'h3c;
		pol = 8'h03;
		adr = iopx_pkg::SLAVE_ADDR_BASE;
		repeat (12) @(posedge clock);
		reset <= 1'b0;
		repeat (4) @(posedge clock);
		@(negedge clock);
		chk("pins_oe", pins_oe, 8'h00);
		chk("drivers", hs | ls, 8'h00);
		reg_rd("out_rst", iopx_pkg::CMD_OUTPUT, 1'b1, iopx_pkg::OUTPUT_RST);
		reg_rd("pol_rst", iopx_pkg::CMD_POLARITY, 1'b1, iopx_pkg::POLARITY_RST);
		reg_rd("cfg_rst", iopx_pkg::CMD_CONFIG, 1'b1, iopx_pkg::CONFIG_RST);
		reg_rd("in", iopx_pkg::CMD_INPUT, 1'b1, 8'h3c);
		reg_rd("in_again", iopx_pkg::CMD_INPUT, 1'b0, 8'h3c);
		@(posedge clock) ext <= 8'h3d;
		al(1'b1, 1'b0);
		@(posedge clock) ext <= 8'h3c;
		al(1'b0, 1'b0);
		@(posedge clock) ext <= 8'h38;
		al(1'b1, 1'b0);
		reg_rd("in_fall", iopx_pkg::CMD_INPUT, 1'b0, 8'h38);
		chk("alert_clr", {7'h00, alert_oe}, 8'h00);
		@(posedge clock) ext <= 8'h3c;
		al(1'b1, 1'b0);
		adr = iopx_pkg::SLAVE_ADDR_BASE + 7'h01;
		xfer(adr, iopx_pkg::CMD_INPUT, 1'b0, 1'b0, 8'h00, 1'b0, v);
		al(1'b1, 1'b1);
		adr = iopx_pkg::SLAVE_ADDR_BASE;
		reg_rd("in_clr", iopx_pkg::CMD_INPUT, 1'b0, 8'h3c);
		al(1'b0, 1'b0);
		reg_wr(iopx_pkg::CMD_CONFIG, 8'h0f);
		reg_wr(iopx_pkg::CMD_OUTPUT, 8'ha5);
		chk("pins_oe", pins_oe, 8'hf0);
		chk("high_side", hs, 8'ha0);
		chk("low_side", ls, 8'h50);
		chk("alert_out", {7'h00, alert_out}, 8'h00);
		al(1'b0, 1'b1);
		reg_wr(iopx_pkg::CMD_OUTPUT, 8'h55);
		al(1'b0, 1'b1);
		reg_rd("out_rb", iopx_pkg::CMD_OUTPUT, 1'b1, 8'h55);
		reg_wr(iopx_pkg::CMD_POLARITY, pol);
		reg_rd("pol_rb", iopx_pkg::CMD_POLARITY, 1'b1, pol);
		reg_rd("in_pol", iopx_pkg::CMD_INPUT, 1'b1, ((8'hf0 & 8'h55) | (8'h0f & ext)) ^ pol);
		@(posedge clock) sel <= 3'h5;
		repeat (8) @(posedge clock);
		xfer(adr, iopx_pkg::CMD_CONFIG, 1'b0, 1'b1, 8'h00, 1'b0, v);
		adr = iopx_pkg::SLAVE_ADDR_BASE + 7'h05;
		reg_rd("cfg_sel", iopx_pkg::CMD_CONFIG, 1'b1, 8'h0f);
		reg_wr(iopx_pkg::CMD_CONFIG, 8'h00);
		reg_wr(iopx_pkg::CMD_OUTPUT, 8'haa);
		chk("high_all", hs, 8'haa);
		al(1'b0, 1'b1);
		reg_wr(iopx_pkg::CMD_CONFIG, 8'hff);
		al(1'b1, 1'b0);
		reg_wr(iopx_pkg::CMD_INPUT, 8'h00);
		reg_rd("in_sw", iopx_pkg::CMD_INPUT, 1'b0, 8'h3c ^ pol);
		al(1'b0, 1'b0);
		close_out();
	end
endmodule // tb_iopx_expander
`default_nettype wire
